// ### core/sff_top.sv
`timescale 1ns/1ns
// serial flash fetch and command controller
module sff_top (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              fetch_req,
	input  wire logic [23:0]       fetch_addr,
	output logic                   fetch_ready,
	output logic      [7:0]        fetch_data,
	output logic                   ext_code_en,
	output logic                   boot_done,
	output logic      [23:0]       code_start_addr,
	input  wire logic              dual_mode_cfg,
	input  wire logic              launch,
	input  wire logic [63:0]       cmd_buffer,
	input  wire logic [7:0]        transfer_length,
	output logic                   xfer_busy,
	output logic      [63:0]       response_buffer,
	output logic                   link_fast,
	output sff_pkg::sff_pins_t     flash_pins,
	input  wire logic              flash_data_out_in,
	input  wire logic              flash_serial_in
);
	sff_pkg::sff_core_t s;
	sff_pkg::sff_core_t n;

	logic        c_we;
	logic        c_re;
	logic [7:0]  c_wd;
	logic        din;
	logic        dq0;
	logic        tick;
	logic        fall;
	logic        rise;
	logic        seq;
	logic        hit;
	logic        take;
	logic        open_ok;
	logic [2:0]  half;
	logic [2:0]  last_bit;
	logic [7:0]  rx_s;
	logic [7:0]  rx_n;
	logic [7:0]  sig_byte;
	logic [23:0] offs;
	logic [63:0] tx_cmd;
	logic [2:0]  resp_idx;

	// cache memory; its read register is the fetch data output
	sff_cache_mem u_cache (
		.clk     (clk),
		.rst_b   (rst_b),
		.wr_en   (c_we),
		.wr_addr (s.cur[4:0]),
		.wr_data (c_wd),
		.rd_en   (c_re),
		.rd_addr (fetch_addr[4:0]),
		.rd_data (fetch_data)
	);

	// shared decode of the current state
	always_comb
	begin
		din      = s.sy2[0];
		dq0      = s.sy2[1];
		half     = s.fast ? sff_pkg::HALF_CYC_HI : sff_pkg::HALF_CYC_STD;
		tick     = (s.div == half);
		fall     = tick && s.pins.sck;
		rise     = tick && !s.pins.sck &&
			(s.st == sff_pkg::ST_XFER || s.st == sff_pkg::ST_RECV);
		last_bit = s.dual ? sff_pkg::BIT_LAST_DUAL : sff_pkg::BIT_LAST_SGL;
		rx_s     = {s.rx[6:0], din};
		rx_n     = s.dual ? {s.rx[5:0], din, dq0} : rx_s;
		sig_byte = sff_pkg::SIG_VALUE[{~s.sig_idx, 3'b000} +: 8];
		seq      = (fetch_addr == s.last_addr + 24'h000001);
		offs     = fetch_addr - s.base;
		hit      = (offs < {18'h00000, s.len});
		open_ok  = (s.st == sff_pkg::ST_IDLE || s.st == sff_pkg::ST_HOLD);
		take     = fetch_req && s.ext_en && open_ok;
		resp_idx = 3'(s.byte_no - 4'h1);
		for (int i = 0; i < 8; i++)
			tx_cmd[63 - 8 * i -: 8] = cmd_buffer[8 * i +: 8];
	end

	// next state of the whole controller
	always_comb
	begin
		n       = s;
		n.ready = 1'b0;
		c_we    = 1'b0;
		c_re    = 1'b0;
		c_wd    = rx_n;
		n.sy1   = {flash_data_out_in, flash_serial_in};
		n.sy2   = s.sy1;
		// link clock runs only while bits move
		if (s.st == sff_pkg::ST_XFER || s.st == sff_pkg::ST_RECV || s.st == sff_pkg::ST_GAP)
		begin
			n.div = tick ? 3'h0 : 3'(s.div + 3'h1);
			if (tick && s.st != sff_pkg::ST_GAP)
				n.pins.sck = ~s.pins.sck;
		end
		case (s.st)
			sff_pkg::ST_STRAP:
			begin
				// data-out undriven so the strap level can be read
				n.strap_cnt = 2'(s.strap_cnt + 2'h1);
				if (s.strap_cnt == sff_pkg::STRAP_WAIT)
				begin
					n.fast       = dq0;
					n.boot       = 1'b1;
					n.sig_ok     = 1'b1;
					n.dual       = 1'b0;
					n.is_cmd     = 1'b0;
					n.tx         = {sff_pkg::OP_FAST_READ, sff_pkg::SIG_ADDR,
						sff_pkg::DUMMY_BYTE, 24'h000000};
					n.bytes_left = sff_pkg::HDR_BYTES;
					n.cur        = sff_pkg::SIG_ADDR;
					n.div        = 3'h0;
					n.st         = sff_pkg::ST_GAP;
				end
			end
			sff_pkg::ST_IDLE, sff_pkg::ST_HOLD:
			begin
				if (take && s.st == sff_pkg::ST_HOLD && seq)
				begin
					// sequential: same burst, one more byte
					n.cur    = fetch_addr;
					n.bit_no = 3'h0;
					n.div    = 3'h0;
					n.st     = sff_pkg::ST_RECV;
				end
				else if (take)
				begin
					n.pins.cs_b = 1'b1;
					n.pins.doe  = 1'b0;
					if (hit)
					begin
						// jump into the cached window
						c_re    = 1'b1;
						n.ready = 1'b1;
						n.st    = sff_pkg::ST_IDLE;
					end
					else
					begin
						n.base       = fetch_addr;
						n.len        = 6'h00;
						n.dual       = dual_mode_cfg && !s.fast;
						n.is_cmd     = 1'b0;
						n.tx         = {(n.dual ? sff_pkg::OP_DUAL_READ :
							sff_pkg::OP_FAST_READ), fetch_addr,
							sff_pkg::DUMMY_BYTE, 24'h000000};
						n.bytes_left = sff_pkg::HDR_BYTES;
						n.cur        = fetch_addr;
						n.div        = 3'h0;
						n.st         = sff_pkg::ST_GAP;
					end
				end
				else if (launch && transfer_length != 8'h00)
				begin
					// register transfer; closes any open burst first
					n.pins.cs_b  = 1'b1;
					n.pins.doe   = 1'b0;
					n.is_cmd     = 1'b1;
					n.dual       = 1'b0;
					n.busy       = 1'b1;
					n.tx         = tx_cmd;
					n.bytes_left = transfer_length;
					n.byte_no    = 4'h0;
					n.resp       = '0;
					n.last_addr  = ~s.last_addr;
					n.len        = 6'h00;
					n.div        = 3'h0;
					n.st         = sff_pkg::ST_GAP;
				end
			end
			sff_pkg::ST_GAP:
			begin
				// select stays high one half period, then drops
				n.pins.sck = 1'b0;
				if (tick)
				begin
					n.pins.cs_b = 1'b0;
					n.pins.doe  = 1'b1;
					n.pins.dout = s.tx[63];
					n.tx        = {s.tx[62:0], 1'b0};
					n.bit_no    = 3'h0;
					n.st        = sff_pkg::ST_XFER;
				end
			end
			sff_pkg::ST_XFER:
			begin
				if (fall)
				begin
					// filler zeros follow once the buffer is shifted out
					n.rx        = rx_s;
					n.pins.dout = s.tx[63];
					n.tx        = {s.tx[62:0], 1'b0};
					n.bit_no    = 3'(s.bit_no + 3'h1);
					if (s.bit_no == sff_pkg::BIT_LAST_SGL)
					begin
						n.bytes_left = 8'(s.bytes_left - 8'h01);
						if (s.byte_no <= sff_pkg::RESP_BYTES)
							n.byte_no = 4'(s.byte_no + 4'h1);
						if (s.byte_no != 4'h0 && s.byte_no <= sff_pkg::RESP_BYTES)
							n.resp[{resp_idx, 3'b000} +: 8] = rx_s;
						if (s.bytes_left == 8'h01)
						begin
							if (s.is_cmd)
							begin
								n.pins.cs_b = 1'b1;
								n.pins.doe  = 1'b0;
								n.busy      = 1'b0;
								n.st        = sff_pkg::ST_IDLE;
							end
							else
							begin
								// dual data phase frees the data-out line
								n.pins.doe = !s.dual;
								n.st       = sff_pkg::ST_RECV;
							end
						end
					end
				end
			end
			sff_pkg::ST_RECV:
			begin
				if (fall)
				begin
					n.rx     = rx_n;
					n.bit_no = 3'(s.bit_no + 3'h1);
					if (s.bit_no == last_bit)
					begin
						n.bit_no = 3'h0;
						if (s.boot)
						begin
							n.sig_ok  = s.sig_ok && (rx_n == sig_byte);
							n.sig_idx = 2'(s.sig_idx + 2'h1);
							n.cur     = 24'(s.cur + 24'h000001);
							if (s.sig_idx == sff_pkg::SIG_LAST)
							begin
								n.pins.cs_b   = 1'b1;
								n.pins.doe    = 1'b0;
								n.boot        = 1'b0;
								n.boot_done   = 1'b1;
								n.ext_en      = n.sig_ok;
								n.start_addr  = sff_pkg::BOOT_ENTRY;
								n.last_addr   = ~sff_pkg::BOOT_ENTRY;
								n.st          = sff_pkg::ST_IDLE;
							end
						end
						else
						begin
							// byte done: cache it and release the stall
							c_we        = 1'b1;
							n.ready     = 1'b1;
							n.last_addr = s.cur;
							n.st        = sff_pkg::ST_HOLD;
							if (s.len == sff_pkg::CACHE_BYTES)
								n.base = 24'(s.base + 24'h000001);
							else
								n.len = 6'(s.len + 6'h01);
						end
					end
				end
			end
			default:
			begin
				n.pins.cs_b = 1'b1;
				n.st        = sff_pkg::ST_IDLE;
			end
		endcase
	end

	// single state register
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			s <= sff_pkg::CORE_RST;
		else
			s <= n;
	end

	// outputs straight from the state register
	assign fetch_ready     = s.ready;
	assign ext_code_en     = s.ext_en;
	assign boot_done       = s.boot_done;
	assign code_start_addr = s.start_addr;
	assign xfer_busy       = s.busy;
	assign response_buffer = s.resp;
	assign link_fast       = s.fast;
	assign flash_pins      = s.pins;

	// link clock counters seen only by the checks below
	logic [10:0] cs_rises;
	logic [3:0]  rx_rises;
	logic [10:0] len_clocks;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cs_rises   <= 11'h000;
			rx_rises   <= 4'h0;
			len_clocks <= 11'h000;
		end
		else
		begin
			if (s.pins.cs_b)
				cs_rises <= 11'h000;
			else if (rise)
				cs_rises <= 11'(cs_rises + 11'h001);
			if (s.st != sff_pkg::ST_RECV)
				rx_rises <= 4'h0;
			else if (rise)
				rx_rises <= 4'(rx_rises + 4'h1);
			if (n.st == sff_pkg::ST_GAP && n.is_cmd && !s.is_cmd)
				len_clocks <= {transfer_length, 3'b000};
			else if (open_ok && launch && !take && transfer_length != 8'h00)
				len_clocks <= {transfer_length, 3'b000};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_jump;
		take && !(s.st == sff_pkg::ST_HOLD && seq);
	endsequence

	sequence s_burst_open;
		$fell(flash_pins.cs_b) && !s.is_cmd && !s.boot;
	endsequence

	a_no_boot_fetch: assert property (fetch_ready |-> ext_code_en)
		else $error("fetch served without valid boot signature");
	a_jump_cs_high: assert property (s_jump |=> flash_pins.cs_b)
		else $error("jump left chip select low");
	a_hit_one_clk: assert property (s_jump and hit |=> fetch_ready && s.st == sff_pkg::ST_IDLE)
		else $error("cache hit not served in one clock");
	a_jump_base_load: assert property (s_jump and !hit |=> s.base == $past(fetch_addr) && s.len == 6'h00)
		else $error("jump did not reload cache base");
	a_seq_burst_keep: assert property (take && s.st == sff_pkg::ST_HOLD && seq
		|=> !flash_pins.cs_b && s.st == sff_pkg::ST_RECV)
		else $error("sequential fetch broke the burst");
	a_cache_len_step: assert property (c_we |=> s.len == (($past(s.len) == sff_pkg::CACHE_BYTES) ?
		sff_pkg::CACHE_BYTES : $past(s.len) + 6'h01))
		else $error("cache length step wrong");
	a_hdr_opcode: assert property (s_burst_open |-> {flash_pins.dout, s.tx[63:57]} ==
		(s.dual ? sff_pkg::OP_DUAL_READ : sff_pkg::OP_FAST_READ))
		else $error("wrong read opcode at burst start");
	a_dual_slow_only: assert property (!flash_pins.doe && !flash_pins.cs_b |-> !link_fast)
		else $error("dual data phase at high link speed");
	a_byte_clocks: assert property (c_we |-> rx_rises == (s.dual ? 4'h4 : 4'h8))
		else $error("fetched byte took wrong clock count");
	a_cmd_clocks: assert property (s.st == sff_pkg::ST_XFER && s.is_cmd && n.st == sff_pkg::ST_IDLE
		|-> cs_rises == len_clocks ##1 flash_pins.cs_b && !xfer_busy)
		else $error("command transfer clock count wrong");
	a_strap_hold: assert property (boot_done |-> $stable(link_fast))
		else $error("speed strap changed after boot");
endmodule

// ### core/sff_pkg.sv
// Functional notes
// - at power-up read flash from 0xFFFA and check the boot signature 2DFU.
// - valid signature enables external code memory, execution starting at 0x0000.
// - missing signature keeps internal ROM; no external code fetch is served.
// - single-mode fetch: chip select low, opcode 0x0B, 24-bit address, dummy byte.
// - single mode takes one byte over eight clocks, then signals ready.
// - sequential fetch keeps chip select low and shifts one more byte.
// - non-sequential fetch ends the burst by raising chip select.
// - dual mode, only at the slower link speed, sends opcode 0x3B, address, dummy.
// - dual mode takes each byte over four clocks, two bits per clock.
// - strap on data-out pin picks link speed, latched at reset release.
// - 32-byte fetch cache; a jump loads the base pointer with the target.
// - each fetched byte enters the cache; base advances past 32 bytes.
// - a jump inside the cached range is served within one clock, no flash access.
// - command transfers use 8-byte command, 8-byte response and byte length.
// - launch drops chip select and gives eight clocks per programmed byte.
// - bytes after the first are sampled from data-in into the response buffer.
// - lengths beyond the command buffer keep clocking with filler on data-out.
// - erase commands use length four; chip select rises at completion.
// - byte program uses opcode 0x02, address, one data byte, length five.
// - single-byte commands use length one, giving eight clocks only.
// - ID read 0x9F with length four leaves three reply bytes in the buffer.
package sff_pkg;
	localparam int          CLK_MHZ        = 100;
	// link half periods; the two speeds keep the documented 2:1 ratio
	localparam int          HALF_NS_STD    = 40;
	localparam int          HALF_NS_HI     = 20;
	localparam logic [2:0]  HALF_CYC_STD   = 3'((HALF_NS_STD * CLK_MHZ) / 1000 - 1);
	localparam logic [2:0]  HALF_CYC_HI    = 3'((HALF_NS_HI * CLK_MHZ) / 1000 - 1);
	localparam logic [7:0]  OP_FAST_READ   = 8'h0b;
	localparam logic [7:0]  OP_DUAL_READ   = 8'h3b;
	localparam logic [7:0]  DUMMY_BYTE     = 8'h00;
	localparam logic [23:0] SIG_ADDR       = 24'h00fffa;
	localparam logic [31:0] SIG_VALUE      = 32'h32444655;
	localparam logic [23:0] BOOT_ENTRY     = 24'h000000;
	localparam logic [7:0]  HDR_BYTES      = 8'h05;
	localparam logic [3:0]  RESP_BYTES     = 4'h8;
	localparam logic [5:0]  CACHE_BYTES    = 6'h20;
	localparam logic [1:0]  STRAP_WAIT     = 2'h3;
	localparam logic [1:0]  SIG_LAST       = 2'h3;
	localparam logic [2:0]  BIT_LAST_SGL   = 3'h7;
	localparam logic [2:0]  BIT_LAST_DUAL  = 3'h3;

	typedef enum logic [2:0] {
		ST_STRAP = 3'b000,
		ST_GAP   = 3'b001,
		ST_XFER  = 3'b010,
		ST_RECV  = 3'b011,
		ST_HOLD  = 3'b100,
		ST_IDLE  = 3'b101
	} sff_state_t;

	// flash link pins; doe high while data-out is driven
	typedef struct packed {
		logic cs_b;
		logic sck;
		logic dout;
		logic doe;
	} sff_pins_t;

	typedef struct packed {
		sff_state_t  st;
		logic [1:0]  sy1;
		logic [1:0]  sy2;
		logic [1:0]  strap_cnt;
		logic        fast;
		logic        boot;
		logic        boot_done;
		logic        ext_en;
		logic        sig_ok;
		logic [1:0]  sig_idx;
		logic [2:0]  div;
		sff_pins_t   pins;
		logic        dual;
		logic        is_cmd;
		logic        busy;
		logic [63:0] tx;
		logic [7:0]  rx;
		logic [2:0]  bit_no;
		logic [7:0]  bytes_left;
		logic [3:0]  byte_no;
		logic [63:0] resp;
		logic [23:0] cur;
		logic [23:0] last_addr;
		logic [23:0] base;
		logic [5:0]  len;
		logic        ready;
		logic [23:0] start_addr;
	} sff_core_t;

	localparam sff_core_t CORE_RST = '{st: ST_STRAP, pins: '{cs_b: 1'b1, default: 1'b0},
		default: '0};
endpackage

// ### core/sff_cache_mem.sv
`timescale 1ns/1ns
// 32-byte fetch cache; read data always leaves a register
module sff_cache_mem (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       wr_en,
	input  wire logic [4:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       rd_en,
	input  wire logic [4:0] rd_addr,
	output logic      [7:0] rd_data
);
	typedef struct packed {
		logic [31:0][7:0] mem;
		logic [7:0]       rd;
	} sff_mem_t;

	sff_mem_t m_q;
	sff_mem_t m_d;

	// a write also passes its byte to the read register
	always_comb
	begin
		m_d = m_q;
		if (wr_en)
		begin
			m_d.mem[wr_addr] = wr_data;
			m_d.rd           = wr_data;
		end
		else if (rd_en)
		begin
			m_d.rd = m_q.mem[rd_addr];
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			m_q <= '0;
		else
			m_q <= m_d;
	end

	assign rd_data = m_q.rd;
endmodule

// ### testbench/sff_flash_model.sv
`timescale 1ns/1ns
// behavioural serial flash: samples on sck rise, answers on sck fall
module sff_flash_model (
	input  wire logic               clk,
	input  wire sff_pkg::sff_pins_t pins,
	input  wire logic               sig_good,
	input  wire logic               strap,
	output logic                    data_out_in,
	output logic                    serial_in
);
	int         cnt = 0;
	int         frames = 0;
	int         nd;
	logic [7:0] rec [0:15];
	logic [7:0] sr;
	logic [7:0] b;
	logic       rd;
	logic       io0 = 1'b0;
	logic       io0_oe = 1'b0;
	logic       drv = 1'b0;
	logic       io1 = 1'b0;

	// image: signature at the boot address when present, a pattern elsewhere
	function automatic logic [7:0] pat(input logic [23:0] a);
		if (sig_good && a >= sff_pkg::SIG_ADDR && a - sff_pkg::SIG_ADDR < 24'h4)
			return sff_pkg::SIG_VALUE[8 * (3 - int'(a - sff_pkg::SIG_ADDR)) +: 8];
		return a[7:0] ^ a[15:8] ^ 8'ha5;
	endfunction

	// reply bytes of command transfers; the values are arbitrary
	function automatic logic [7:0] rep(input int i);
		return 8'h3c ^ 8'(i * 17);
	endfunction

	// data-out pin: design while enabled, flash in dual reads, else the strap pull
	assign data_out_in = pins.doe ? pins.dout : (io0_oe ? io0 : strap);
	assign serial_in = io1;

	// a frame starts with chip select falling
	always @(negedge pins.cs_b)
	begin
		cnt = 0;
		frames = frames + 1;
	end

	// collect what the design shifts out, mode 0
	always @(posedge pins.sck)
	begin
		if (!pins.cs_b)
		begin
			sr = {sr[6:0], pins.dout};
			cnt = cnt + 1;
			if (cnt % 8 == 0 && cnt <= 128)
				rec[cnt / 8 - 1] = sr;
		end
	end

	// answers change on the falling edge and hold for a full period
	always @(negedge pins.sck)
	begin
		if (!pins.cs_b && cnt >= 8)
		begin
			rd = rec[0] == sff_pkg::OP_FAST_READ || rec[0] == sff_pkg::OP_DUAL_READ;
			drv <= 1'b1;
			if (rec[0] == sff_pkg::OP_FAST_READ && cnt >= 40)
			begin
				nd = cnt - 40;
				b = pat({rec[1], rec[2], rec[3]} + 24'(nd / 8));
				io1 <= b[7 - nd % 8];
			end
			else if (rec[0] == sff_pkg::OP_DUAL_READ && cnt >= 40)
			begin
				nd = cnt - 40;
				b = pat({rec[1], rec[2], rec[3]} + 24'(nd / 4));
				{io1, io0} <= b[6 - 2 * (nd % 4) +: 2];
				io0_oe <= 1'b1;
			end
			else if (!rd)
			begin
				nd = cnt - 8;
				b = rep(nd / 8);
				io1 <= b[7 - nd % 8];
			end
			else
				drv <= 1'b0;
		end
	end

	// released lines: data-in toggles so a stale value never looks valid
	always @(posedge pins.cs_b)
	begin
		drv <= 1'b0;
		io0_oe <= 1'b0;
	end
	always @(posedge clk)
		if (!drv)
			io1 <= ~io1;
endmodule

// ### testbench/sff_top_bench.sv
`timescale 1ns/1ns
// self-checking bench for the serial flash fetch controller
module sff_top_bench;
	logic               clk = 1'b0;
	logic               rst_b = 1'b0;
	logic               fetch_req = 1'b0;
	logic [23:0]        fetch_addr = '0;
	logic               fetch_ready;
	logic [7:0]         fetch_data;
	logic               ext_code_en;
	logic               boot_done;
	logic [23:0]        code_start_addr;
	logic               dual_mode_cfg = 1'b0;
	logic               launch = 1'b0;
	logic [63:0]        cmd_buffer = '0;
	logic [7:0]         transfer_length = '0;
	logic               xfer_busy;
	logic [63:0]        response_buffer;
	logic               link_fast;
	sff_pkg::sff_pins_t flash_pins;
	logic               data_out_in;
	logic               serial_in;
	logic               strap = 1'b0;
	logic               sig_good = 1'b0;
	int                 num_errors = 0;
	int                 samples_checked = 0;
	int                 n;
	int                 f;

	// 100 MHz clock
	always #5 clk = ~clk;

	sff_top i_sff_top (.clk(clk), .rst_b(rst_b), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .fetch_data(fetch_data),
		.ext_code_en(ext_code_en), .boot_done(boot_done), .code_start_addr(code_start_addr),
		.dual_mode_cfg(dual_mode_cfg), .launch(launch), .cmd_buffer(cmd_buffer),
		.transfer_length(transfer_length), .xfer_busy(xfer_busy),
		.response_buffer(response_buffer), .link_fast(link_fast), .flash_pins(flash_pins),
		.flash_data_out_in(data_out_in), .flash_serial_in(serial_in));

	sff_flash_model i_flash (.clk(clk), .pins(flash_pins), .sig_good(sig_good),
		.strap(strap), .data_out_in(data_out_in), .serial_in(serial_in));

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// one step of a bounded wait; running out ends the run
	task automatic tick(input int lim);
		@(negedge clk);
		n++;
		if (n > lim)
		begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, n, lim);
			summarize();
		end
	endtask

	function automatic logic [7:0] pat(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'ha5;
	endfunction

	function automatic logic [7:0] rep(input int i);
		return 8'h3c ^ 8'(i * 17);
	endfunction

	// opcode and address of the last frame seen by the flash
	function automatic logic [31:0] hdr();
		return {i_flash.rec[0], i_flash.rec[1], i_flash.rec[2], i_flash.rec[3]};
	endfunction

	// reset with a strap level and an image with or without signature
	task automatic do_reset(input logic s, input logic g);
		rst_b = 1'b0;
		strap = s;
		sig_good = g;
		f = i_flash.frames;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		n = 0;
		while (boot_done !== 1'b1)
			tick(5000);
		check(i_flash.frames - f, 1);
		check(hdr(), {sff_pkg::OP_FAST_READ, sff_pkg::SIG_ADDR});
		check(i_flash.cnt, 72);
		check(ext_code_en, g);
		check(link_fast, s);
	endtask

	// one fetch; n counts falling edges until ready
	task automatic fetch(input logic [23:0] a);
		fetch_addr = a;
		fetch_req = 1'b1;
		n = 0;
		tick(3000);
		fetch_req = 1'b0;
		while (fetch_ready !== 1'b1)
			tick(3000);
		check(fetch_data, pat(a));
	endtask

	task automatic t_boot_bad;
		do_reset(1'b0, 1'b0);
		f = i_flash.frames;
		fetch_req = 1'b1;
		@(negedge clk);
		fetch_req = 1'b0;
		n = 0;
		repeat (200)
		begin
			@(negedge clk);
			if (fetch_ready !== 1'b0 || flash_pins.cs_b !== 1'b1)
				n++;
		end
		check(n, 0);
		check(i_flash.frames, f);
		$display("test boot_bad done");
	endtask

	task automatic t_single;
		do_reset(1'b0, 1'b1);
		check(code_start_addr, sff_pkg::BOOT_ENTRY);
		fetch(sff_pkg::BOOT_ENTRY);
		check(hdr(), {sff_pkg::OP_FAST_READ, sff_pkg::BOOT_ENTRY});
		check(i_flash.cnt, 48);
		f = i_flash.frames;
		for (int i = 1; i < 4; i++)
		begin
			fetch(24'(i));
			check(i_flash.cnt, 48 + 8 * i);
		end
		check(flash_pins.cs_b, 1'b0);
		check(i_flash.frames, f);
		fetch(24'h40);
		check(i_flash.frames, f + 1);
		check(hdr(), {sff_pkg::OP_FAST_READ, 24'h40});
		$display("test single done");
	endtask

	task automatic t_cache;
		for (int i = 1; i < 40; i++)
			fetch(24'h40 + 24'(i));
		f = i_flash.frames;
		fetch(24'h50);
		check(n, 1);
		check(i_flash.frames, f);
		fetch(24'h47);
		check(i_flash.frames, f + 1);
		fetch(24'h48);
		fetch(24'h47);
		check(n, 1);
		check(i_flash.frames, f + 1);
		$display("test cache done");
	endtask

	task automatic t_dual;
		dual_mode_cfg = 1'b1;
		do_reset(1'b0, 1'b1);
		fetch(24'h20);
		check(hdr(), {sff_pkg::OP_DUAL_READ, 24'h20});
		check(i_flash.cnt, 44);
		fetch(24'h21);
		check(i_flash.cnt, 48);
		do_reset(1'b1, 1'b1);
		fetch(24'h30);
		check(hdr(), {sff_pkg::OP_FAST_READ, 24'h30});
		check(n < 48 * 2 * 4, 1'b1);
		dual_mode_cfg = 1'b0;
		$display("test dual done");
	endtask

	task automatic t_cmds;
		logic [63:0] bufs [0:7];
		int          lens [0:7];
		// three erases, a program, short commands, an id read, an overlong run
		bufs = '{64'h5634_1220, 64'h1_0052, 64'h3_00d8, 64'ha5_4567_0102,
			64'h5e, 64'h9f, 64'h8877_6655_4433_2211, 64'h71};
		lens = '{4, 4, 4, 5, 1, 4, 10, 1};
		for (int k = 0; k < 8; k++)
		begin
			cmd_buffer = bufs[k];
			transfer_length = 8'(lens[k]);
			launch = 1'b1;
			@(negedge clk);
			launch = 1'b0;
			check(xfer_busy, 1'b1);
			n = 0;
			while (xfer_busy !== 1'b0)
				tick(2000);
			check(i_flash.cnt, 8 * lens[k]);
			check({flash_pins.cs_b, flash_pins.doe}, 2'b10);
			for (int j = 0; j < lens[k] && j < 8; j++)
				check(i_flash.rec[j], bufs[k][8 * j +: 8]);
			for (int j = 0; j < lens[k] - 1 && j < 8; j++)
				check(response_buffer[8 * j +: 8], rep(j));
		end
		// a zero length launch is ignored
		transfer_length = 8'h00;
		launch = 1'b1;
		@(negedge clk);
		launch = 1'b0;
		check(xfer_busy, 1'b0);
		$display("test cmds done");
	endtask

	initial
	begin
		t_boot_bad();
		t_single();
		t_cache();
		t_dual();
		t_cmds();
		summarize();
	end
endmodule
